// ==== sscfg_pkg.sv ====
// Purpose: Constants for the second soft strap configuration register bank
// Assumes: 16-bit management registers, word addressed
// Notes: Offsets, field positions and reset values live here
package sscfg_pkg;
	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [4:0] SSCFG_OFF_CTRL_ONE = 5'h09;
	localparam logic [4:0] SSCFG_OFF_CTRL_TWO = 5'h0a;
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int SSCFG_BIT_DONE = 15;
	localparam int SSCFG_BIT_MDIX_FAST = 6;
	localparam int SSCFG_BIT_MDIX_ROBUST = 5;
	localparam int SSCFG_BIT_FAST_LINK = 6;
	localparam int SSCFG_BIT_FD_EXT = 5;
	localparam int SSCFG_BIT_LED_FD = 4;
	localparam int SSCFG_BIT_HD_ISO = 3;
	localparam int SSCFG_BIT_IDLE_ERR = 2;
	localparam int SSCFG_BIT_ODD_DIS = 1;
	localparam int SSCFG_BIT_RX_CLK = 0;
	// Writable bits of register two: 13:0
	localparam logic [15:0] SSCFG_TWO_WMASK = 16'h3fff;
	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [15:0] SSCFG_TWO_RESET = 16'h0004;
	localparam logic [15:0] SSCFG_ONE_RESET = 16'h0000;
	// Length of internal strap reset pulse in cycles
	localparam logic [1:0] SSCFG_PULSE_CYCLES = 2'h2;
	// ----------------------------------------
	// Sequencer states
	// ----------------------------------------
	typedef enum logic [1:0] {SSCFG_IDLE, SSCFG_PULSE, SSCFG_DONE} sscfg_state_t;
endpackage

// ==== sscfg_oddnib.sv ====
// Purpose: Odd-nibble transmit end detection and extension
// Assumes: One call per transmit nibble clock tick
// Notes: Extends enable by one cycle with error forced when ending odd
`timescale 1ns/1ps
`default_nettype none
module sscfg_oddnib (
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic reset_in,
	// Configuration
	input wire logic odd_disable_in,
	// Transmit nibble stream
	input wire logic tx_en_in,
	input wire logic tx_er_in,
	output logic tx_en_out,
	output logic tx_er_out
);
	logic parity_r, parity_nxt;
	logic en_r, en_nxt;
	logic er_r, er_nxt;
	logic ext_r, ext_nxt;

	// Next nibble parity and extension
	always_comb begin
		parity_nxt = tx_en_in ? ~parity_r : 1'b0;
		ext_nxt = 1'b0;
		en_nxt = tx_en_in;
		er_nxt = tx_er_in & tx_en_in;
		if (!tx_en_in && parity_r && !odd_disable_in && !ext_r) begin
			en_nxt = 1'b1;
			er_nxt = 1'b1;
			ext_nxt = 1'b1;
		end
	end

	// Register stage
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			parity_r <= 1'b0;
			en_r <= 1'b0;
			er_r <= 1'b0;
			ext_r <= 1'b0;
		end else begin
			parity_r <= parity_nxt;
			en_r <= en_nxt;
			er_r <= er_nxt;
			ext_r <= ext_nxt;
		end
	end

	assign tx_en_out = en_r;
	assign tx_er_out = er_r;

	// Disabled detection never forces error after enable drops
	a_odd_disabled: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		(odd_disable_in && !tx_en_in) |=> !tx_er_out)
		else $error("odd nibble error flagged while disabled");
	a_odd_extend: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		($fell(tx_en_in) && $past(parity_r) == 1'b0 && parity_r && !odd_disable_in && !ext_r)
		|=> (tx_en_out && tx_er_out))
		else $error("odd nibble end not extended with error");
endmodule
`default_nettype wire

// ==== sscfg_top.sv ====
// Purpose: Second soft strap configuration register with latch on config done
// Assumes: Register port strobes are single cycle, synchronous to ref_clk_in
// Notes: Register one stores the whole written word; only done and crossover bits are used here
//
// Operation
// - Setting done bit pulses internal reset and latches software straps.
// - Bits 15 and 14 ignore writes and read zero.
// - Fast link-up bit selects shortened parallel detect link time.
// - Fast or robust crossover mode forces fast link-up bit on.
// - Extended full duplex forces full duplex against forced 100 partner.
// - Without extension, duplex follows standard resolution.
// - Link LED option lights LED only on 100 full duplex.
// - Isolation option isolates MII outputs on 100 half duplex link.
// - Idle symbol error detection follows option bit, default one.
// - Odd-nibble enable end extends enable one cycle with error.
// - Odd-nibble disable bit suppresses that transmit error.
// - RMII receive data referenced to receive clock or crystal clock.
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module sscfg_top (
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic reset_in,
	// Register port
	input wire logic [4:0] reg_addr_in,
	input wire logic [15:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [15:0] reg_rdata_out,
	// Link status from the PHY core
	input wire logic link_up_in,
	input wire logic link_100_in,
	input wire logic an_enable_in,
	input wire logic forced_100_in,
	input wire logic partner_forced_100_in,
	input wire logic ieee_full_duplex_in,
	// Receive path status
	input wire logic idle_state_in,
	input wire logic symbol_error_in,
	input wire logic rmii_mode_in,
	input wire logic rx_clk_in,
	input wire logic crystal_input_clock_in,
	// Transmit nibble stream
	input wire logic tx_en_in,
	input wire logic tx_er_in,
	// Configuration and effects
	output logic strap_reset_out,
	output logic fast_link_up_out,
	output logic full_duplex_out,
	output logic link_led_out,
	output logic mii_isolate_out,
	output logic idle_rx_error_out,
	output logic rx_sample_clk_out,
	output logic tx_en_out,
	output logic tx_er_out
);
	// ----------------------------------------
	// Register file
	// ----------------------------------------
	logic [15:0] two_r, two_nxt;
	logic [15:0] one_r, one_nxt;
	logic [15:0] rdata_r, rdata_nxt;
	logic wr_two, wr_one;
	// Sequencer state, declared here because the done-bit clear reads it
	sscfg_pkg::sscfg_state_t state_r, state_nxt;

	assign wr_two = reg_wr_in && (reg_addr_in == sscfg_pkg::SSCFG_OFF_CTRL_TWO);
	assign wr_one = reg_wr_in && (reg_addr_in == sscfg_pkg::SSCFG_OFF_CTRL_ONE);

	// Write storage and read mux
	always_comb begin
		two_nxt = two_r;
		one_nxt = one_r;
		rdata_nxt = 16'h0000;
		if (wr_two) begin
			two_nxt = reg_wdata_in & sscfg_pkg::SSCFG_TWO_WMASK;
		end
		if (wr_one) begin
			one_nxt = reg_wdata_in;
		end
		// Done bit clears itself once the pulse ends
		if (state_r == sscfg_pkg::SSCFG_DONE) begin
			one_nxt[sscfg_pkg::SSCFG_BIT_DONE] = wr_one && reg_wdata_in[sscfg_pkg::SSCFG_BIT_DONE];
		end
		if (reg_rd_in) begin
			case (reg_addr_in)
				sscfg_pkg::SSCFG_OFF_CTRL_TWO: rdata_nxt = two_r & sscfg_pkg::SSCFG_TWO_WMASK;
				sscfg_pkg::SSCFG_OFF_CTRL_ONE: rdata_nxt = one_r;
				default: rdata_nxt = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			two_r <= sscfg_pkg::SSCFG_TWO_RESET;
			one_r <= sscfg_pkg::SSCFG_ONE_RESET;
			rdata_r <= 16'h0000;
		end else begin
			two_r <= two_nxt;
			one_r <= one_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign reg_rdata_out = rdata_r;

	// ----------------------------------------
	// Strap latch sequencer
	// ----------------------------------------
	logic [1:0] cnt_r, cnt_nxt;
	logic [15:0] act_r, act_nxt;
	logic pulse_r, pulse_nxt;

	// Done bit triggers pulse, latch at pulse end
	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		act_nxt = act_r;
		pulse_nxt = 1'b0;
		case (state_r)
			sscfg_pkg::SSCFG_IDLE: begin
				if (one_r[sscfg_pkg::SSCFG_BIT_DONE]) begin
					state_nxt = sscfg_pkg::SSCFG_PULSE;
					cnt_nxt = sscfg_pkg::SSCFG_PULSE_CYCLES;
					pulse_nxt = 1'b1;
				end
			end
			sscfg_pkg::SSCFG_PULSE: begin
				pulse_nxt = 1'b1;
				cnt_nxt = cnt_r - 2'h1;
				if (cnt_r == 2'h1) begin
					pulse_nxt = 1'b0;
					act_nxt = two_r;
					// Crossover modes force fast link-up
					if (one_r[sscfg_pkg::SSCFG_BIT_MDIX_FAST] || one_r[sscfg_pkg::SSCFG_BIT_MDIX_ROBUST]) begin
						act_nxt[sscfg_pkg::SSCFG_BIT_FAST_LINK] = 1'b1;
					end
					state_nxt = sscfg_pkg::SSCFG_DONE;
				end
			end
			sscfg_pkg::SSCFG_DONE: begin
				state_nxt = sscfg_pkg::SSCFG_IDLE;
			end
			default: state_nxt = sscfg_pkg::SSCFG_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			state_r <= sscfg_pkg::SSCFG_IDLE;
			cnt_r <= 2'h0;
			act_r <= sscfg_pkg::SSCFG_TWO_RESET;
			pulse_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			act_r <= act_nxt;
			pulse_r <= pulse_nxt;
		end
	end

	assign strap_reset_out = pulse_r;

	// ----------------------------------------
	// Configuration effects
	// ----------------------------------------
	logic fast_r, fast_nxt;
	logic fd_r, fd_nxt;
	logic led_r, led_nxt;
	logic iso_r, iso_nxt;
	logic idle_r, idle_nxt;
	logic rxclk_r, rxclk_nxt;

	// Effects of latched configuration
	always_comb begin
		fast_nxt = act_r[sscfg_pkg::SSCFG_BIT_FAST_LINK];
		if (act_r[sscfg_pkg::SSCFG_BIT_FD_EXT] && partner_forced_100_in && (an_enable_in || forced_100_in)) begin
			fd_nxt = 1'b1;
		end else begin
			fd_nxt = ieee_full_duplex_in;
		end
		if (act_r[sscfg_pkg::SSCFG_BIT_LED_FD]) begin
			led_nxt = link_up_in && link_100_in && fd_nxt;
		end else begin
			led_nxt = link_up_in;
		end
		iso_nxt = act_r[sscfg_pkg::SSCFG_BIT_HD_ISO] && link_up_in && link_100_in && !fd_nxt;
		idle_nxt = act_r[sscfg_pkg::SSCFG_BIT_IDLE_ERR] && idle_state_in && symbol_error_in;
		if (rmii_mode_in && act_r[sscfg_pkg::SSCFG_BIT_RX_CLK]) begin
			rxclk_nxt = rx_clk_in;
		end else begin
			rxclk_nxt = crystal_input_clock_in;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			fast_r <= 1'b0;
			fd_r <= 1'b0;
			led_r <= 1'b0;
			iso_r <= 1'b0;
			idle_r <= 1'b0;
			rxclk_r <= 1'b0;
		end else begin
			fast_r <= fast_nxt;
			fd_r <= fd_nxt;
			led_r <= led_nxt;
			iso_r <= iso_nxt;
			idle_r <= idle_nxt;
			rxclk_r <= rxclk_nxt;
		end
	end

	assign fast_link_up_out = fast_r;
	assign full_duplex_out = fd_r;
	assign link_led_out = led_r;
	assign mii_isolate_out = iso_r;
	assign idle_rx_error_out = idle_r;
	assign rx_sample_clk_out = rxclk_r;

	// Odd-nibble handling on the transmit stream
	sscfg_oddnib u_oddnib (
		.ref_clk_in(ref_clk_in),
		.reset_in(reset_in),
		.odd_disable_in(act_r[sscfg_pkg::SSCFG_BIT_ODD_DIS]),
		.tx_en_in(tx_en_in),
		.tx_er_in(tx_er_in),
		.tx_en_out(tx_en_out),
		.tx_er_out(tx_er_out)
	);

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_done_pulse: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		(state_r == sscfg_pkg::SSCFG_IDLE && one_r[sscfg_pkg::SSCFG_BIT_DONE]) |=> strap_reset_out [*2])
		else $error("done bit did not give a two cycle strap pulse");
	a_reserved_zero: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		$past(reg_rd_in) |-> reg_rdata_out[15:14] == 2'h0 || $past(reg_addr_in) != sscfg_pkg::SSCFG_OFF_CTRL_TWO)
		else $error("reserved bits read nonzero");
	a_latch_only: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		(state_r != sscfg_pkg::SSCFG_PULSE) |=> $stable(act_r))
		else $error("active configuration changed outside the pulse");
	a_fast_forced: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		(state_r == sscfg_pkg::SSCFG_PULSE && cnt_r == 2'h1 && (one_r[6] || one_r[5])) |=> ##1 fast_link_up_out)
		else $error("crossover mode did not force fast link-up");
	a_fd_extend: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		(act_r[5] && partner_forced_100_in && (an_enable_in || forced_100_in)) |=> full_duplex_out)
		else $error("extended full duplex not applied");
	a_fd_ieee: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		(!act_r[5] && $stable(act_r)) |=> full_duplex_out == $past(ieee_full_duplex_in))
		else $error("duplex did not follow standard resolution");
	a_led_fd: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		(act_r[4] && !link_100_in) |=> !link_led_out)
		else $error("enhanced link LED lit off 100 full duplex");
	a_iso_hd: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		mii_isolate_out |-> $past(act_r[3] && link_up_in && link_100_in))
		else $error("MII isolated without 100 half duplex link");
	a_idle_err: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		(!act_r[2]) |=> !idle_rx_error_out)
		else $error("idle symbol error flagged while disabled");
	a_rx_clk: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		(rmii_mode_in && act_r[0]) |=> rx_sample_clk_out == $past(rx_clk_in))
		else $error("receive sampling clock not taken from receive clock");
endmodule
`default_nettype wire

// ==== sscfg_host.sv ====
// Purpose: Host processor model on the strap register port
// Assumes: Single-cycle strobes, read data in the next cycle only
// Notes: Strap values go in first, done bit last
`timescale 1ns/1ps
`default_nettype none
module sscfg_host (
	// Clock
	input wire logic clk_in,
	// Register port
	output logic [4:0] addr_out,
	output logic [15:0] wdata_out,
	output logic wr_out,
	output logic rd_out,
	input wire logic [15:0] rdata_in
);
	// Quiet bus from time zero
	initial begin
		addr_out = 5'h00;
		wdata_out = 16'h0000;
		wr_out = 1'b0;
		rd_out = 1'b0;
	end
	// One-cycle write strobe
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge clk_in);
		addr_out <= a;
		wdata_out <= d;
		wr_out <= 1'b1;
		@(posedge clk_in);
		wr_out <= 1'b0;
	endtask
	// One-cycle read strobe, data taken in the following cycle
	task automatic rd(input logic [4:0] a, output logic [15:0] d);
		@(posedge clk_in);
		addr_out <= a;
		rd_out <= 1'b1;
		@(posedge clk_in);
		rd_out <= 1'b0;
		@(negedge clk_in);
		d = rdata_in;
	endtask
	// Straps before the done bit
	task automatic load(input logic [15:0] two, input logic [15:0] one);
		wr(sscfg_pkg::SSCFG_OFF_CTRL_TWO, two);
		wr(sscfg_pkg::SSCFG_OFF_CTRL_ONE, one | 16'h8000);
	endtask
endmodule
`default_nettype wire

// ==== soft_strap_config_two_tb.sv ====
// Purpose: Self-checking bench for the second strap register
// Assumes: Reset config 0x0004, effects settle within two cycles
// Notes: Status inputs packed in st, link status in the top bits
`timescale 1ns/1ps
`default_nettype none
module soft_strap_config_two_tb;
	logic ref_clk_in, reset_in, wr, rd, tx_en, tx_er;
	logic [4:0] addr;
	logic [15:0] wdata, rdata;
	logic [10:0] st;
	logic sr, fl, fd, led, iso, ier, rxs, teo, tero;
	int n_mismatch, num_checks;
	// ----------------------------------------
	// Clock, host and design
	// ----------------------------------------
	initial begin
		ref_clk_in = 1'b0;
		forever #50 ref_clk_in = ~ref_clk_in;
	end
	sscfg_host u_host (.clk_in(ref_clk_in), .addr_out(addr), .wdata_out(wdata), .wr_out(wr), .rd_out(rd),
		.rdata_in(rdata));
	sscfg_top u_dut (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
		.reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .link_up_in(st[10]), .link_100_in(st[9]),
		.an_enable_in(st[8]), .forced_100_in(st[7]), .partner_forced_100_in(st[6]), .ieee_full_duplex_in(st[5]),
		.idle_state_in(st[4]), .symbol_error_in(st[3]), .rmii_mode_in(st[2]), .rx_clk_in(st[1]),
		.crystal_input_clock_in(st[0]), .tx_en_in(tx_en), .tx_er_in(tx_er), .strap_reset_out(sr),
		.fast_link_up_out(fl), .full_duplex_out(fd), .link_led_out(led), .mii_isolate_out(iso),
		.idle_rx_error_out(ier), .rx_sample_clk_out(rxs), .tx_en_out(teo), .tx_er_out(tero));
	// Compare and count
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Status in, then duplex, LED, isolate, idle error, sample clock out
	task automatic eff(input logic [10:0] v, input logic [4:0] e);
		@(posedge ref_clk_in);
		st <= v;
		repeat (2) @(posedge ref_clk_in);
		@(negedge ref_clk_in);
		chk({11'h000, fd, led, iso, ier, rxs}, {11'h000, e});
	endtask
	// Load straps, count pulse cycles, see done bit clear
	task automatic latch(input logic [15:0] two, input logic [15:0] one);
		int n;
		logic [15:0] d;
		n = 0;
		u_host.load(two, one);
		repeat (8) begin
			@(negedge ref_clk_in);
			n += sr;
		end
		chk(n[15:0], 16'h0002);
		u_host.rd(5'h09, d);
		chk(d & 16'h8000, 16'h0000);
	endtask
	// Three-nibble frame, count enable and error cycles out
	task automatic odd(input logic [15:0] exp_en, input logic [15:0] exp_er);
		int ne, nr;
		ne = 0;
		nr = 0;
		for (int i = 0; i < 10; i++) begin
			@(posedge ref_clk_in);
			tx_en <= (i < 3);
			@(negedge ref_clk_in);
			ne += teo;
			nr += tero;
		end
		chk(ne[15:0], exp_en);
		chk(nr[15:0], exp_er);
	endtask
	// Verdict
	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// Hang guard
	initial begin
		#(5000 * 100);
		n_mismatch++;
		final_report();
	end
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		logic [15:0] d;
		n_mismatch = 0;
		num_checks = 0;
		reset_in = 1'b1;
		st = 11'h000;
		tx_en = 1'b0;
		tx_er = 1'b0;
		repeat (5) @(posedge ref_clk_in);
		reset_in <= 1'b0;
		u_host.rd(5'h0a, d);
		chk(d, 16'h0004);
		eff(11'h75e, 5'b01010);
		u_host.wr(5'h0a, 16'hffff);
		u_host.rd(5'h0a, d);
		chk(d, 16'h3fff);
		eff(11'h75e, 5'b01010);
		chk({15'h0000, fl}, 16'h0000);
		u_host.rd(5'h1f, d);
		chk(d, 16'h0000);
		latch(16'h3fff, 16'h0000);
		chk({15'h0000, fl}, 16'h0001);
		eff(11'h75e, 5'b11011);
		eff(11'h71e, 5'b00111);
		eff(11'h640, 5'b00100);
		eff(11'h6c0, 5'b11000);
		odd(16'h0003, 16'h0000);
		latch(16'h0000, 16'h0000);
		chk({15'h0000, fl}, 16'h0000);
		eff(11'h75e, 5'b01000);
		eff(11'h57d, 5'b11001);
		odd(16'h0004, 16'h0001);
		latch(16'h0000, 16'h0040);
		chk({15'h0000, fl}, 16'h0001);
		latch(16'h0000, 16'h0020);
		chk({15'h0000, fl}, 16'h0001);
		final_report();
	end
endmodule
`default_nettype wire
